// ### xad_pkg.sv
package xad_pkg;

    // Instruction word layout
    localparam int OPCODE_WIDTH = 14;
    localparam int DATA_WIDTH   = 8;
    localparam int ADDR_WIDTH   = 7;
    localparam int DEST_BIT     = 7;

    // Encodings
    localparam logic [10:0] DIR_LOAD_PREFIX = 11'h00C;  // 00 0000 0110 0 (top 11 bits)
    localparam logic [5:0]  XOR_LIT_PREFIX  = 6'h3A;    // 11 1010
    localparam logic [5:0]  XOR_REG_PREFIX  = 6'h06;    // 00 0110

    // Valid direction register selectors
    localparam logic [2:0] DIR_SEL_MIN = 3'h5;
    localparam logic [2:0] DIR_SEL_MAX = 3'h7;
    localparam int         DIR_COUNT   = 3;

    // Data-memory addresses of the direction registers
    localparam logic [6:0] DIR_ADDR_BASE = 7'h05;

    // Reset values
    localparam logic [7:0] W_RESET   = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;

    // Decoded operation
    typedef enum logic [3:0] {
        XAD_OP_NONE     = 4'h1,
        XAD_OP_DIR_LOAD = 4'h2,
        XAD_OP_XOR_LIT  = 4'h4,
        XAD_OP_XOR_REG  = 4'h8
    } xad_op_t;

endpackage

// ### xad_decode.sv
`timescale 1ns/1ps
module xad_decode (
    // Instruction word
    input  wire logic [13:0] instr,
    // Decoded operation
    output xad_pkg::xad_op_t op
);

    // Pure decode; unknown words map to no operation
    always_comb begin
        if (instr[13:3] == xad_pkg::DIR_LOAD_PREFIX
                && instr[2:0] >= xad_pkg::DIR_SEL_MIN) begin
            op = xad_pkg::XAD_OP_DIR_LOAD;
        end else if (instr[13:8] == xad_pkg::XOR_LIT_PREFIX) begin
            op = xad_pkg::XAD_OP_XOR_LIT;
        end else if (instr[13:8] == xad_pkg::XOR_REG_PREFIX) begin
            op = xad_pkg::XAD_OP_XOR_REG;
        end else begin
            op = xad_pkg::XAD_OP_NONE;
        end
    end

endmodule

// ### xad_core.sv
`timescale 1ns/1ps
// What this block does
// [RULE_01] Direction-load op copies W into direction register 5..7; flags untouched.
// [RULE_02] Direction registers are also readable and writable through data-memory addresses.
// [RULE_03] Software should write direction registers by address, not the legacy op.
// [RULE_04] Literal-XOR puts W xor literal into W, updates only zero, one cycle.
// [RULE_05] Register-XOR computes W xor addressed register, updates only zero, one cycle.
// [RULE_06] Register-XOR destination bit 0 writes W, bit 1 writes addressed register.
// [RULE_07] Zero flag is set when the XOR result is zero, cleared otherwise.
module xad_core (
    // Clock and control
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clock_enable,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    // Data-memory read data for the addressed register (outside direction space)
    input  wire logic [7:0]  mem_rdata,
    // Data-memory direct access from other instructions
    input  wire logic        bus_write,
    input  wire logic [6:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    // Write-back to data memory
    output logic             mem_write,
    output logic      [6:0]  mem_addr,
    output logic      [7:0]  mem_wdata,
    // Core state
    output logic      [7:0]  w_reg,
    output logic             zero_flag,
    output logic             zero_write,
    output logic      [23:0] direction
);

    xad_pkg::xad_op_t op;
    logic [7:0]  dir_q [xad_pkg::DIR_COUNT];
    logic [7:0]  operand;
    logic [7:0]  next_result;
    logic [6:0]  f_addr;
    logic        f_is_dir;
    logic [1:0]  f_idx;
    logic [1:0]  bus_idx;
    logic        bus_is_dir;
    logic        fire;

    xad_decode u_decode (
        .instr (instr),
        .op    (op)
    );

    // A stalled slot counts as no instruction at all
    assign fire       = instr_valid && clock_enable;
    // Indices mean something only while the matching address is in direction space
    assign f_addr     = instr[6:0];
    assign f_is_dir   = f_addr >= xad_pkg::DIR_ADDR_BASE
                        && f_addr <= {4'h0, xad_pkg::DIR_SEL_MAX};
    assign f_idx      = 2'(f_addr - xad_pkg::DIR_ADDR_BASE);
    assign bus_is_dir = bus_addr >= xad_pkg::DIR_ADDR_BASE
                        && bus_addr <= {4'h0, xad_pkg::DIR_SEL_MAX};
    assign bus_idx    = 2'(bus_addr - xad_pkg::DIR_ADDR_BASE);

    // Operand source: literal or register, direction registers served locally
    // The old direction value is read, so a same-edge bus write is not seen here
    always_comb begin
        if (op == xad_pkg::XAD_OP_XOR_LIT) begin
            operand = instr[7:0];
        end else if (f_is_dir) begin
            operand = dir_q[f_idx]; // RULE_02
        end else begin
            operand = mem_rdata;
        end
        next_result = w_reg ^ operand; // RULE_04
    end

    // Working register
    always_ff @(posedge clock) begin
        if (reset) begin
            w_reg <= xad_pkg::W_RESET;
        end else if (fire) begin
            case (op)
                xad_pkg::XAD_OP_XOR_LIT: begin
                    w_reg <= next_result; // RULE_04
                end
                xad_pkg::XAD_OP_XOR_REG: begin
                    if (!instr[xad_pkg::DEST_BIT]) begin
                        w_reg <= next_result; // RULE_06
                    end
                end
                default: begin
                    w_reg <= w_reg;
                end
            endcase
        end
    end

    // Zero flag; direction load leaves it alone
    always_ff @(posedge clock) begin
        if (reset) begin
            zero_flag  <= 1'b0;
            zero_write <= 1'b0;
        end else if (clock_enable) begin
            zero_write <= 1'b0;
            if (instr_valid && (op == xad_pkg::XAD_OP_XOR_LIT
                    || op == xad_pkg::XAD_OP_XOR_REG)) begin
                zero_flag  <= (next_result == 8'h00); // RULE_07
                zero_write <= 1'b1; // RULE_05
            end
        end
    end

    // Direction registers, one per selector; legacy op, register-XOR and direct writes
    genvar g;
    generate
        for (g = 0; g < xad_pkg::DIR_COUNT; g++) begin : g_dir
            always_ff @(posedge clock) begin
                if (reset) begin
                    dir_q[g] <= xad_pkg::DIR_RESET;
                end else if (fire && op == xad_pkg::XAD_OP_DIR_LOAD
                        && 2'(instr[2:0] - xad_pkg::DIR_SEL_MIN) == 2'(g)) begin
                    dir_q[g] <= w_reg; // RULE_01
                end else if (fire && op == xad_pkg::XAD_OP_XOR_REG
                        && instr[xad_pkg::DEST_BIT] && f_is_dir && f_idx == 2'(g)) begin
                    dir_q[g] <= next_result; // RULE_06
                end else if (clock_enable && bus_write && bus_is_dir
                        && bus_idx == 2'(g)) begin
                    dir_q[g] <= bus_wdata; // RULE_02
                end
            end
            assign direction[8*g +: 8] = dir_q[g];
            // Legacy load lands the old W in the selected register
            dir_load_data_a: assert property (@(posedge clock) disable iff (reset) // RULE_01
                fire && op == xad_pkg::XAD_OP_DIR_LOAD
                && 2'(instr[2:0] - xad_pkg::DIR_SEL_MIN) == 2'(g) |=> dir_q[g] == $past(w_reg)
            ) else $error("direction load data wrong");
        end
    endgenerate

    // Registered outputs: bus readback and memory write-back
    // Readback shows the value before any write taking effect on the same edge
    always_ff @(posedge clock) begin
        if (reset) begin
            bus_rdata <= 8'h00;
            mem_write <= 1'b0;
            mem_addr  <= 7'h00;
            mem_wdata <= 8'h00;
        end else if (clock_enable) begin
            bus_rdata <= bus_is_dir ? dir_q[bus_idx] : 8'h00; // RULE_02
            mem_write <= fire && op == xad_pkg::XAD_OP_XOR_REG
                         && instr[xad_pkg::DEST_BIT] && !f_is_dir; // RULE_06
            mem_addr  <= f_addr;
            mem_wdata <= next_result;
        end
    end

    // Legacy load never touches flags or W
    dir_load_flags_a: assert property (@(posedge clock) disable iff (reset) // RULE_01
        fire && op == xad_pkg::XAD_OP_DIR_LOAD |=> !zero_write && $stable(w_reg)
    ) else $error("direction load altered flags or W");

    // Literal XOR result in W
    xor_lit_w_a: assert property (@(posedge clock) disable iff (reset) // RULE_04
        fire && op == xad_pkg::XAD_OP_XOR_LIT |=> w_reg == ($past(w_reg) ^ $past(instr[7:0]))
    ) else $error("literal xor result wrong");

    // Zero flag follows result
    zero_flag_a: assert property (@(posedge clock) disable iff (reset) // RULE_07
        fire && op == xad_pkg::XAD_OP_XOR_LIT |=> zero_flag == (w_reg == 8'h00)
    ) else $error("zero flag mismatch");

    // Register XOR into W also drives the zero flag from the new W
    xor_reg_zero_a: assert property (@(posedge clock) disable iff (reset) // RULE_07
        fire && op == xad_pkg::XAD_OP_XOR_REG && !instr[xad_pkg::DEST_BIT]
        |=> zero_flag == (w_reg == 8'h00)
    ) else $error("register xor zero flag mismatch");

    // Register XOR to memory keeps W
    xor_reg_dest_a: assert property (@(posedge clock) disable iff (reset) // RULE_06
        fire && op == xad_pkg::XAD_OP_XOR_REG && instr[7] |=> $stable(w_reg) && zero_write
    ) else $error("register xor destination wrong");

    // Write-back outside direction space leaves as a strobe one enabled cycle wide
    mem_writeback_a: assert property (@(posedge clock) disable iff (reset) // RULE_06
        fire && op == xad_pkg::XAD_OP_XOR_REG && instr[xad_pkg::DEST_BIT] && !f_is_dir
        |=> mem_write && mem_addr == $past(instr[6:0])
            && mem_wdata == ($past(w_reg) ^ $past(mem_rdata))
    ) else $error("register xor write-back wrong");

    // Direction targets stay inside the block, so memory must not see a write
    dir_internal_a: assert property (@(posedge clock) disable iff (reset) // RULE_06
        fire && op == xad_pkg::XAD_OP_XOR_REG && instr[xad_pkg::DEST_BIT] && f_is_dir
        |=> !mem_write && zero_write
    ) else $error("direction target leaked to memory");

    // Register XOR completes in one cycle
    xor_reg_cycle_a: assert property (@(posedge clock) disable iff (reset) // RULE_05
        fire && op == xad_pkg::XAD_OP_XOR_REG && !instr[7] && !f_is_dir
        |=> w_reg == ($past(w_reg) ^ $past(mem_rdata))
    ) else $error("register xor not done in one cycle");

    // Flag update strobe is one enabled cycle wide
    zero_strobe_a: assert property (@(posedge clock) disable iff (reset) // RULE_05
        clock_enable && !(fire && (op == xad_pkg::XAD_OP_XOR_LIT
            || op == xad_pkg::XAD_OP_XOR_REG)) |=> !zero_write
    ) else $error("zero strobe outstayed its cycle");

    // Refused words change nothing visible; a bus write would hide that
    refused_quiet_a: assert property (@(posedge clock) disable iff (reset) // RULE_01
        fire && op == xad_pkg::XAD_OP_NONE && !bus_write
        |=> $stable(w_reg) && $stable(direction) && $stable(zero_flag) && !zero_write
    ) else $error("refused word changed state");

    // Direct write reaches direction register
    dir_direct_a: assert property (@(posedge clock) disable iff (reset) // RULE_02
        clock_enable && bus_write && bus_is_dir && !fire
        |=> dir_q[$past(bus_idx)] == $past(bus_wdata)
    ) else $error("direct direction write lost");

    // Addresses outside direction space read back as zero
    bus_read_zero_a: assert property (@(posedge clock) disable iff (reset) // RULE_02
        clock_enable && !bus_is_dir |=> bus_rdata == 8'h00
    ) else $error("readback outside direction space not zero");

endmodule

// ### tb_xor_and_direction_load_ops.sv
`timescale 1ns/1ps
module tb_xor_and_direction_load_ops;
    logic        clock, reset, clock_enable, instr_valid, bus_write;
    logic [13:0] instr;
    logic [7:0]  mem_rdata, bus_wdata, bus_rdata, mem_wdata, w_reg;
    logic [6:0]  bus_addr, mem_addr;
    logic        mem_write, zero_flag, zero_write;
    logic [23:0] direction;
    logic [7:0]  mw, mdir[3];
    logic        mz;
    int          fail_count, cmp_count, seed;

    xad_core dut_u (.clock(clock), .reset(reset), .clock_enable(clock_enable),
        .instr_valid(instr_valid), .instr(instr), .mem_rdata(mem_rdata),
        .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .w_reg(w_reg), .zero_flag(zero_flag),
        .zero_write(zero_write), .direction(direction));

    // 250 MHz core clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Four-state compare so an unknown never passes
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One issue slot: drive on the falling edge, step the model, compare a cycle later
    task automatic step(input logic [13:0] i, input logic v, ce, bw, input logic [6:0] ba,
                        input logic [7:0] bd, md);
        logic [7:0] ow, od[3], r;
        logic [6:0] f;
        logic       ezw, emw, hit, lit;
        ow = mw;
        od = mdir;
        f = i[6:0];
        ezw = 1'b0;
        emw = 1'b0;
        r = 8'h00;
        hit = f >= 7'h05 && f <= 7'h07;
        lit = i[13:8] == xad_pkg::XOR_LIT_PREFIX;
        instr = i;
        instr_valid = v;
        clock_enable = ce;
        bus_write = bw;
        bus_addr = ba;
        bus_wdata = bd;
        mem_rdata = md;
        // Bus write first so a colliding instruction overrides it
        if (ce && bw && ba >= 7'h05 && ba <= 7'h07) mdir[ba - 5] = bd;
        if (ce && v && i[13:3] == 11'h00C && i[2:0] >= 3'h5) mdir[i[2:0] - 5] = ow;
        if (ce && v && (lit || i[13:8] == xad_pkg::XOR_REG_PREFIX)) begin
            r = ow ^ (lit ? i[7:0] : hit ? od[f - 5] : md);
            mz = (r == 8'h00);
            ezw = 1'b1;
            if (lit || !i[7]) mw = r;
            else if (hit) mdir[f - 5] = r;
            else emw = 1'b1;
        end
        @(negedge clock);
        chk("w_reg", {16'h0000, mw}, {16'h0000, w_reg});
        chk("zero_flag", {23'h0, mz}, {23'h0, zero_flag});
        chk("direction", {mdir[2], mdir[1], mdir[0]}, direction);
        if (ce) begin
            chk("zero_write", {23'h0, ezw}, {23'h0, zero_write});
            chk("mem_write", {23'h0, emw}, {23'h0, mem_write});
            if (emw) chk("mem_addr", {17'h0, f}, {17'h0, mem_addr});
            if (emw) chk("mem_wdata", {16'h0, r}, {16'h0, mem_wdata});
            // Readback is registered, so it shows the value before a same-edge write
            if (ba < 7'h05 || ba > 7'h07) chk("bus_rdata", 24'h0, {16'h0, bus_rdata});
            else chk("bus_rdata", {16'h0, od[ba - 5]}, {16'h0, bus_rdata});
        end
    endtask

    // Watchdog well beyond the planned run length
    initial begin
        #20000;
        fail_count++;
        print_verdict();
    end

    initial begin
        logic [31:0] k;
        logic [13:0] op;
        seed = 53487;
        fail_count = 0;
        cmp_count = 0;
        reset = 1'b1;
        clock_enable = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        bus_write = 1'b0;
        bus_addr = 7'h00;
        bus_wdata = 8'h00;
        mem_rdata = 8'h00;
        mw = 8'h00;
        mz = 1'b0;
        mdir = '{8'hFF, 8'hFF, 8'hFF};
        repeat (10) @(negedge clock);
        reset = 1'b0;
        chk("direction", 24'hFFFFFF, direction);
        chk("w_reg", 24'h0, {16'h0, w_reg});
        // Worked example, then a zero result
        step(14'h3AB5, 1'b1, 1'b1, 1'b0, 7'h00, 8'h00, 8'h00);
        step(14'h3AAF, 1'b1, 1'b1, 1'b0, 7'h00, 8'h00, 8'h00);
        step(14'h3A1A, 1'b1, 1'b1, 1'b0, 7'h00, 8'h00, 8'h00);
        step(14'h3A96, 1'b1, 1'b1, 1'b0, 7'h00, 8'h00, 8'h00);
        // All selectors, each racing a bus write; valid ones hit the same register
        for (int s = 0; s < 8; s++)
            step({11'h00C, s[2:0]}, 1'b1, 1'b1, 1'b1, 7'(5 + (s + 1) % 3), 8'h3C, 8'h00);
        // Register-XOR, both destinations, direction and plain addresses
        step({xad_pkg::XOR_REG_PREFIX, 8'h86}, 1'b1, 1'b1, 1'b0, 7'h06, 8'h00, 8'h55);
        step({xad_pkg::XOR_REG_PREFIX, 8'h05}, 1'b1, 1'b1, 1'b0, 7'h05, 8'h00, 8'h55);
        step({xad_pkg::XOR_REG_PREFIX, 8'hA0}, 1'b1, 1'b1, 1'b0, 7'h07, 8'h00, 8'h0F);
        // Software path: direction registers written and read back by address only
        for (int a = 5; a < 8; a++)
            step(14'h0000, 1'b0, 1'b1, 1'b1, 7'(a), 8'(8'hA0 + a), 8'h00);
        for (int a = 5; a < 8; a++)
            step(14'h0000, 1'b0, 1'b1, 1'b0, 7'(a), 8'h00, 8'h00);
        // Random mix with stalls, bus traffic and unknown words
        repeat (600) begin
            k = $random(seed);
            case (k[1:0])
                2'd0: op = {11'h00C, k[4:2]};
                2'd1: op = {xad_pkg::XOR_LIT_PREFIX, k[12:5]};
                2'd2: op = {xad_pkg::XOR_REG_PREFIX, k[7], k[8] ? {4'h0, k[4:2]} : k[15:9]};
                default: op = k[29:16];
            endcase
            step(op, k[20:19] != 2'b00, k[31:29] != 3'h0, k[13],
                 k[9] ? {4'h0, k[12:10]} : k[27:21], k[23:16], k[31:24]);
        end
        print_verdict();
    end
endmodule
